// ==== hw/lsp_pkg.sv ====
`default_nettype none

package lsp_pkg;

  // fixed target addresses of the two variants
  localparam logic [6:0] ADDR_VARIANT_A = 7'h29;
  localparam logic [6:0] ADDR_VARIANT_B = 7'h10;
  localparam int RW_BIT = 0;

  // command codes
  localparam logic [7:0] CMD_CONF0 = 8'h00;
  localparam logic [7:0] CMD_CONF1 = 8'h01;
  localparam logic [7:0] CMD_THR_HI_L = 8'h04;
  localparam logic [7:0] CMD_THR_HI_H = 8'h05;
  localparam logic [7:0] CMD_THR_LO_L = 8'h06;
  localparam logic [7:0] CMD_THR_LO_H = 8'h07;
  localparam logic [7:0] CMD_LIGHT_L = 8'h10;
  localparam logic [7:0] CMD_LIGHT_H = 8'h11;
  localparam logic [7:0] CMD_IR_L = 8'h12;
  localparam logic [7:0] CMD_IR_H = 8'h13;
  localparam logic [7:0] CMD_ID_L = 8'h14;
  localparam logic [7:0] CMD_ID_H = 8'h15;
  localparam logic [7:0] CMD_INT_EVT = 8'h17;

  // reset values and field positions
  localparam logic [7:0] CONF0_RST = 8'h01;
  localparam logic [7:0] CONF1_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam int CORE_PD_BIT = 0;
  localparam int INT_EN_BIT = 1;
  localparam int TRIG_BIT = 2;
  localparam int CHAN_PD_BIT = 7;
  localparam logic [7:0] TRIG_MASK = 8'h04;

  // byte framing
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE = 4'h1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] PHASE_ADDR = 2'h0;
  localparam logic [1:0] PHASE_CMD = 2'h1;
  localparam logic [1:0] PHASE_DATA = 2'h2;

  // serial clock range and stuck-low timeout
  localparam int SCL_MIN_HZ = 10_000;
  localparam int SCL_MAX_HZ = 400_000;
  localparam int CLK_HZ = 200_000_000;
  localparam int TIMEOUT_MIN_MS = 25;
  localparam int TIMEOUT_MAX_MS = 35;
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MIN_MS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_RACK = 3'b100
  } lsp_state_t;

endpackage : lsp_pkg

`default_nettype wire

// ==== hw/lsp_target.sv ====
// Operation
// - the port works with serial clocks from 10 kHz to 400 kHz in standard and fast modes.
// - variant one answers at 7-bit address 0x29, write byte 0x52 and read byte 0x53.
// - variant two answers at 7-bit address 0x10, write byte 0x20 and read byte 0x21.
// - the address byte's lowest bit picks direction, 0 for host write and 1 for host read.
// - every register access names its register with an 8-bit command code after the address; a read sent without one starts at the held pointer.
// - codes 0x00 to 0x17 are decoded, and 0x02, 0x03, 0x08 to 0x0F and 0x16 map to nothing.
// - on entering shutdown the last measurement stays in the result registers.
// - result registers stay readable in shutdown and return the kept measurement.
// - a clock or data line held low for 25 ms to 35 ms is taken as a bus timeout.
// - the interrupt pin is open drain, pulled low only while asserted.
// - register 0x00 reads 0x01 after reset, so the device starts shut down.
// - bit 0 of register 0x00 shuts the core supply down at 1 and turns it on at 0.
// - bit 7 of register 0x01 shuts both light channels down at 1 and enables them at 0.
// - the 16-bit light result reads as low byte at 0x10 and high byte at 0x11.
`default_nettype none

module lsp_target #(
  parameter bit ADDR_SEL = 1'b0,
  parameter int TIMEOUT_CYC = lsp_pkg::TIMEOUT_CYC,
  parameter logic [7:0] ID_LOW = 8'h5A,  // arbitrary value
  parameter logic [7:0] ID_HIGH = 8'hA5  // arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output var logic o_sda_out,
  output var logic o_sda_oe,
  input wire logic i_result_valid,
  input wire logic [15:0] i_light_result,
  input wire logic [15:0] i_ir_result,
  input wire logic i_int_req,
  input wire logic [7:0] i_int_flags,
  output var logic o_int_out,
  output var logic o_int_oe,
  output var logic [7:0] o_conf0,
  output var logic [7:0] o_conf1,
  output var logic o_core_power_down,
  output var logic o_channel_power_down,
  output var logic [15:0] o_thr_high,
  output var logic [15:0] o_thr_low,
  output var logic o_trig,
  output var logic o_bus_timeout
);

  localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_TOP = TMO_W'(TIMEOUT_CYC);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYC - 1);
  localparam logic [TMO_W-1:0] TMO_ZERO = '0;

  lsp_pkg::lsp_state_t state_r;
  logic scl_q_r;
  logic scl_d_r;
  logic sda_q_r;
  logic sda_d_r;
  logic [lsp_pkg::BIT_CNT_W-1:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [1:0] phase_r;
  logic rw_r;
  logic [7:0] ptr_r;
  logic [TMO_W-1:0] low_cnt_r;
  logic [7:0] conf0_r;
  logic [7:0] conf1_r;
  logic [15:0] thr_hi_r;
  logic [15:0] thr_lo_r;
  logic [15:0] light_r;
  logic [15:0] ir_r;

  // read-back decode of one command code
  function automatic logic [7:0] rd_byte(input logic [7:0] code);
    logic [7:0] val;
    val = lsp_pkg::BYTE_ZERO;  // undefined and reserved codes read zero
    case (code)
      lsp_pkg::CMD_CONF0: val = conf0_r;
      lsp_pkg::CMD_CONF1: val = conf1_r;
      lsp_pkg::CMD_THR_HI_L: val = thr_hi_r[7:0];
      lsp_pkg::CMD_THR_HI_H: val = thr_hi_r[15:8];
      lsp_pkg::CMD_THR_LO_L: val = thr_lo_r[7:0];
      lsp_pkg::CMD_THR_LO_H: val = thr_lo_r[15:8];
      lsp_pkg::CMD_LIGHT_L: val = light_r[7:0];
      lsp_pkg::CMD_LIGHT_H: val = light_r[15:8];
      lsp_pkg::CMD_IR_L: val = ir_r[7:0];
      lsp_pkg::CMD_IR_H: val = ir_r[15:8];
      lsp_pkg::CMD_ID_L: val = ID_LOW;
      lsp_pkg::CMD_ID_H: val = ID_HIGH;
      lsp_pkg::CMD_INT_EVT: val = i_int_flags;
      default: val = lsp_pkg::BYTE_ZERO;
    endcase
    return val;
  endfunction : rd_byte

  // line sampling for edge and condition detection
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_q_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_q_r <= i_scl;
      scl_d_r <= scl_q_r;
      sda_q_r <= i_sda;
      sda_d_r <= sda_q_r;
    end
  end

  // bus events; edges are seen at any rate up to the fast-mode clock
  wire scl_rise = scl_q_r & ~scl_d_r;
  wire scl_fall = ~scl_q_r & scl_d_r;
  wire start_cond = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
  wire stop_cond = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;

  // address match against the selected variant
  wire [6:0] own_addr = ADDR_SEL ? lsp_pkg::ADDR_VARIANT_B
                                 : lsp_pkg::ADDR_VARIANT_A;
  wire addr_hit = (shift_r[7:1] == own_addr);
  wire byte_done = (state_r == lsp_pkg::ST_RX) & scl_fall & (bit_cnt_r == lsp_pkg::BYTE_BITS);
  wire in_addr = (phase_r == lsp_pkg::PHASE_ADDR);
  wire in_cmd = (phase_r == lsp_pkg::PHASE_CMD);
  wire in_data = (phase_r == lsp_pkg::PHASE_DATA);
  wire [7:0] rd_sel = rd_byte(ptr_r);
  wire [7:0] ptr_inc = ptr_r + 8'h01;
  wire [1:0] phase_inc = in_data ? lsp_pkg::PHASE_DATA : phase_r + 2'h1;

  // register write strobes, one byte per data phase
  wire wr_stb = byte_done & in_data;
  wire wr_conf0 = wr_stb & (ptr_r == lsp_pkg::CMD_CONF0);
  wire wr_conf1 = wr_stb & (ptr_r == lsp_pkg::CMD_CONF1);
  wire wr_hi_l = wr_stb & (ptr_r == lsp_pkg::CMD_THR_HI_L);
  wire wr_hi_h = wr_stb & (ptr_r == lsp_pkg::CMD_THR_HI_H);
  wire wr_lo_l = wr_stb & (ptr_r == lsp_pkg::CMD_THR_LO_L);
  wire wr_lo_h = wr_stb & (ptr_r == lsp_pkg::CMD_THR_LO_H);

  // stuck-low watch on either line
  wire lines_high = scl_q_r & sda_q_r;
  wire timeout_hit = (low_cnt_r == TMO_LAST);

  // low-time counter, saturates so the timeout fires once per episode
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || lines_high) begin
      low_cnt_r <= TMO_ZERO;
    end else if (low_cnt_r != TMO_TOP) begin
      low_cnt_r <= low_cnt_r + TMO_W'(1);
    end
  end

  // byte-level transfer machine
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r <= lsp_pkg::ST_IDLE;
      bit_cnt_r <= lsp_pkg::BIT_CNT_ZERO;
      shift_r <= lsp_pkg::BYTE_ZERO;
      phase_r <= lsp_pkg::PHASE_ADDR;
      rw_r <= 1'b0;
      ptr_r <= lsp_pkg::BYTE_ZERO;
      o_sda_oe <= 1'b0;
    end else if (timeout_hit || stop_cond) begin
      state_r <= lsp_pkg::ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (start_cond) begin
      // start or repeated start restarts address reception
      state_r <= lsp_pkg::ST_RX;
      bit_cnt_r <= lsp_pkg::BIT_CNT_ZERO;
      phase_r <= lsp_pkg::PHASE_ADDR;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (state_r)
        lsp_pkg::ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        lsp_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_q_r};
            bit_cnt_r <= bit_cnt_r + lsp_pkg::BIT_CNT_ONE;
          end else if (byte_done) begin
            bit_cnt_r <= lsp_pkg::BIT_CNT_ZERO;
            phase_r <= phase_inc;
            if (in_addr && !addr_hit) begin
              state_r <= lsp_pkg::ST_IDLE;
            end else begin
              state_r <= lsp_pkg::ST_ACK;
              o_sda_oe <= 1'b1;
            end
            if (in_addr) begin
              rw_r <= shift_r[lsp_pkg::RW_BIT];
            end
            if (in_cmd) begin
              ptr_r <= shift_r;
            end
            if (in_data) begin
              ptr_r <= ptr_inc;  // low then high byte
            end
          end
        end
        lsp_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              shift_r <= rd_sel;
              o_sda_oe <= ~rd_sel[7];
              bit_cnt_r <= lsp_pkg::BIT_CNT_ONE;
              state_r <= lsp_pkg::ST_TX;
            end else begin
              o_sda_oe <= 1'b0;
              state_r <= lsp_pkg::ST_RX;
            end
          end
        end
        lsp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == lsp_pkg::BYTE_BITS) begin
              o_sda_oe <= 1'b0;
              state_r <= lsp_pkg::ST_RACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              o_sda_oe <= ~shift_r[6];
              bit_cnt_r <= bit_cnt_r + lsp_pkg::BIT_CNT_ONE;
            end
          end
        end
        lsp_pkg::ST_RACK: begin
          if (scl_rise) begin
            if (sda_q_r) begin
              state_r <= lsp_pkg::ST_IDLE;
            end else begin
              ptr_r <= ptr_inc;  // high byte follows low
            end
          end else if (scl_fall) begin
            shift_r <= rd_sel;
            o_sda_oe <= ~rd_sel[7];
            bit_cnt_r <= lsp_pkg::BIT_CNT_ONE;
            state_r <= lsp_pkg::ST_TX;
          end
        end
        default: begin
          state_r <= lsp_pkg::ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // configuration registers; 0x00 and 0x01 each take their own data byte on its own strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      conf0_r <= lsp_pkg::CONF0_RST;
      conf1_r <= lsp_pkg::CONF1_RST;
      o_trig <= 1'b0;
    end else begin
      if (wr_conf0) begin
        conf0_r <= shift_r & ~lsp_pkg::TRIG_MASK;  // trigger bit self-clears
      end
      if (wr_conf1) begin
        conf1_r <= shift_r;
      end
      o_trig <= wr_conf0 & shift_r[lsp_pkg::TRIG_BIT];
    end
  end

  // threshold window registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      thr_hi_r <= lsp_pkg::WORD_ZERO;
      thr_lo_r <= lsp_pkg::WORD_ZERO;
    end else begin
      if (wr_hi_l) thr_hi_r[7:0] <= shift_r;
      if (wr_hi_h) thr_hi_r[15:8] <= shift_r;
      if (wr_lo_l) thr_lo_r[7:0] <= shift_r;
      if (wr_lo_h) thr_lo_r[15:8] <= shift_r;
    end
  end

  // power-down controls decoded from the configuration
  wire core_pd = conf0_r[lsp_pkg::CORE_PD_BIT];
  wire chan_pd = conf1_r[lsp_pkg::CHAN_PD_BIT];
  wire shut_down = core_pd | chan_pd;

  // results captured only while running, held through shutdown
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      light_r <= lsp_pkg::WORD_ZERO;
      ir_r <= lsp_pkg::WORD_ZERO;
    end else if (i_result_valid && !shut_down) begin
      light_r <= i_light_result;
      ir_r <= i_ir_result;
    end
  end

  // output flops: open-drain pins drive low only when enabled
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
      o_int_out <= 1'b0;
      o_int_oe <= 1'b0;
      o_bus_timeout <= 1'b0;
      o_core_power_down <= 1'b1;
      o_channel_power_down <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_int_out <= 1'b0;
      o_int_oe <= i_int_req & conf0_r[lsp_pkg::INT_EN_BIT];
      o_bus_timeout <= timeout_hit;
      o_core_power_down <= core_pd;
      o_channel_power_down <= chan_pd;
    end
  end

  // configuration mirrors for the sensing core
  assign o_conf0 = conf0_r;
  assign o_conf1 = conf1_r;
  assign o_thr_high = thr_hi_r;
  assign o_thr_low = thr_lo_r;

endmodule : lsp_target

`default_nettype wire

// ==== sim/lsp_checker.sv ====
`default_nettype none

module lsp_checker #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_int_req,
  input wire logic o_int_out,
  input wire logic o_int_oe,
  input wire logic [7:0] o_conf0,
  input wire logic [7:0] o_conf1,
  input wire logic o_core_power_down,
  input wire logic o_channel_power_down,
  input wire logic o_bus_timeout
);
  timeunit 1ns;
  timeprecision 100ps;
  int scl_cnt;
  int sda_cnt;
  logic to_seen_r;

  // low-time counters per line, and a flag for a timeout within the current low stretch
  always_ff @(posedge i_ref_clk) begin
    scl_cnt <= (i_rst || i_scl) ? 0 : scl_cnt + 1;
    sda_cnt <= (i_rst || i_sda) ? 0 : sda_cnt + 1;
    to_seen_r <= (i_rst || (i_scl && i_sda)) ? 1'h0 : (to_seen_r || o_bus_timeout);
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_pins_open_drain: assert property (!o_sda_out && !o_int_out)
    else $error("open drain pin drives a high level");
  a_int_gate: assert property (!$past(i_rst) |-> o_int_oe == ($past(i_int_req) && $past(o_conf0[1])))
    else $error("interrupt pin does not follow the enabled request");
  a_reset_values: assert property ($fell(i_rst) |-> o_conf0 == 8'h01 && o_conf1 == 8'h00 && o_core_power_down)
    else $error("configuration not at its reset value");
  a_core_pd_follow: assert property (!$past(i_rst) |-> o_core_power_down == $past(o_conf0[0]))
    else $error("core power down does not follow its bit");
  a_chan_pd_follow: assert property (!$past(i_rst) |-> o_channel_power_down == $past(o_conf1[7]))
    else $error("channel power down does not follow its bit");
  a_timeout_late: assert property (o_bus_timeout |-> scl_cnt >= TIMEOUT_CYC - 6 || sda_cnt >= TIMEOUT_CYC - 6)
    else $error("timeout flagged before the low time ran out");
  a_timeout_due: assert property (scl_cnt == TIMEOUT_CYC + 6 || sda_cnt == TIMEOUT_CYC + 6 |-> to_seen_r)
    else $error("stuck low line not flagged");
  a_timeout_frees: assert property (o_bus_timeout |=> !o_sda_oe [*4])
    else $error("data line held after a timeout");
  a_drive_stands: assert property ($rose(o_sda_oe) |=> o_sda_oe [*8])
    else $error("data drive dropped within a clock low phase");
  a_drive_on_low: assert property ($changed(o_sda_oe) && !o_bus_timeout && !$past(o_bus_timeout) |-> !i_scl)
    else $error("data drive changed while the clock is high");

  cover property ($rose(o_sda_oe));
  cover property (o_bus_timeout);
  cover property ($fell(o_core_power_down));
  cover property ($rose(o_int_oe));
endmodule : lsp_checker

bind lsp_target lsp_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_lsp_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_int_req(i_int_req),
  .o_int_out(o_int_out), .o_int_oe(o_int_oe), .o_conf0(o_conf0), .o_conf1(o_conf1),
  .o_core_power_down(o_core_power_down), .o_channel_power_down(o_channel_power_down),
  .o_bus_timeout(o_bus_timeout));

`default_nettype wire

// ==== sim/lsp_host.sv ====
`default_nettype none

module lsp_host #(
  parameter int QTR = 5  // quarter bit in clocks, scaled with the shortened timeout
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output var logic o_scl,
  output var logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idle: both lines released high
  initial begin
    o_scl = 1'h1;
    o_sda_oe = 1'h0;
  end

  // wait n edges, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // one bit: data moves only while the clock is low, sampled with the clock high
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe = !b;
    tick(QTR);
    o_scl = 1'h1;
    tick(QTR);
    s = i_sda;
    tick(QTR);
    o_scl = 1'h0;
    tick(QTR);
  endtask : bit_io

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    o_sda_oe = 1'h0;
    tick(QTR);
    o_scl = 1'h1;
    tick(QTR);
    o_sda_oe = 1'h1;
    tick(QTR);
    o_scl = 1'h0;
    tick(QTR);
  endtask : start_cond

  // stop: data rises while the clock is high
  task automatic stop_cond();
    o_sda_oe = 1'h1;
    tick(QTR);
    o_scl = 1'h1;
    tick(QTR);
    o_sda_oe = 1'h0;
    tick(QTR);
  endtask : stop_cond

  // eight bits most significant first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : lsp_host

`default_nettype wire

// ==== sim/lsp_target_bench.sv ====
`default_nettype none

module lsp_target_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TO_CYC = 2000;
  logic clk;
  logic rst;
  logic rvalid;
  logic [15:0] light;
  logic [15:0] ir;
  logic int_req;
  logic [7:0] flags;
  logic scl;
  logic h_oe;
  logic oe_a;
  logic oe_b;
  logic nk_any;
  logic hi_seen = 1'h0;
  int trig_cnt = 0;
  wire logic sda_out_a;
  wire logic int_out_a;
  wire logic int_oe_a;
  wire logic cpd_a;
  wire logic chpd_a;
  wire logic trig_a;
  wire logic to_a;
  wire logic [7:0] conf0_a;
  wire logic [7:0] conf1_a;
  wire logic [15:0] thr_hi_a;
  wire logic [15:0] thr_lo_a;
  wire logic sda_out_b;
  wire logic int_out_b;
  wire logic trig_b;
  wire logic to_b;
  wire logic [7:0] conf0_b;
  wire logic [7:0] conf1_b;
  logic to_seen = 1'h0;
  logic [7:0] undef [5] = '{8'h02, 8'h08, 8'h0A, 8'h0E, 8'h16};
  int fail_count = 0;
  int num_checks = 0;
  wire logic sda;

  // pulled-up data line, low while any party drives it
  assign sda = !(h_oe || oe_a || oe_b);

  lsp_host #(.QTR(5)) host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
  lsp_target #(.ADDR_SEL(1'h0), .TIMEOUT_CYC(TO_CYC)) dut (.i_ref_clk(clk), .i_rst(rst), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out_a), .o_sda_oe(oe_a), .i_result_valid(rvalid), .i_light_result(light),
    .i_ir_result(ir), .i_int_req(int_req), .i_int_flags(flags), .o_int_out(int_out_a), .o_int_oe(int_oe_a),
    .o_conf0(conf0_a), .o_conf1(conf1_a), .o_core_power_down(cpd_a), .o_channel_power_down(chpd_a),
    .o_thr_high(thr_hi_a), .o_thr_low(thr_lo_a), .o_trig(trig_a), .o_bus_timeout(to_a));
  lsp_target #(.ADDR_SEL(1'h1), .TIMEOUT_CYC(TO_CYC)) dut_b (.i_ref_clk(clk), .i_rst(rst), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out_b), .o_sda_oe(oe_b), .i_result_valid(rvalid), .i_light_result(light),
    .i_ir_result(ir), .i_int_req(int_req), .i_int_flags(flags), .o_int_out(int_out_b), .o_int_oe(),
    .o_conf0(conf0_b), .o_conf1(conf1_b), .o_core_power_down(), .o_channel_power_down(), .o_thr_high(),
    .o_thr_low(), .o_trig(trig_b), .o_bus_timeout(to_b));

  // free-running clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // sticky watchers on the timeout pulses and on the drive values of the open-drain pins, and a count of trigger pulses
  always @(posedge clk) begin
    if (to_a && to_b) to_seen <= 1'h1;
    if (trig_a || trig_b) trig_cnt <= trig_cnt + 1;
    if (sda_out_a || int_out_a || sda_out_b || int_out_b) hi_seen <= 1'h1;
  end

  // expected word read from an undefined code: only a following 0x17 byte carries data
  function automatic logic [15:0] exp_undef(input logic [7:0] c, input logic [7:0] f);
    return (c == 8'h16) ? {f, 8'h00} : 16'h0000;
  endfunction : exp_undef

  // expected configuration byte 0 after a write: the trigger bit never reads back
  function automatic logic [7:0] exp_conf0(input logic [7:0] v);
    return v & 8'hFB;
  endfunction : exp_conf0

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // byte helpers: put collects any missing acknowledge, get ignores its own
  task automatic put(input logic [7:0] b);
    logic [7:0] rx;
    logic a;
    host.xfer(b, 1'h1, rx, a);
    nk_any |= a;
  endtask : put
  task automatic get(input logic last, output logic [7:0] b);
    logic a;
    host.xfer(8'hFF, last, b, a);
  endtask : get

  // word write: address, code, low byte, high byte
  task automatic wr_word(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d);
    nk_any = 1'h0;
    host.start_cond();
    put(a);
    put(c);
    put(d[7:0]);
    put(d[15:8]);
    host.stop_cond();
    check({15'h0000, nk_any}, 16'h0000);
  endtask : wr_word

  // word read: code, repeated start, low byte first, nack on the last
  task automatic rd_word(input logic [7:0] c, output logic [15:0] d);
    nk_any = 1'h0;
    host.start_cond();
    put(8'h52);
    put(c);
    host.start_cond();
    put(8'h53);
    get(1'h0, d[7:0]);
    get(1'h1, d[15:8]);
    host.stop_cond();
    check({15'h0000, nk_any}, 16'h0000);
  endtask : rd_word

  task automatic meas(input logic [15:0] v);
    light = v;
    ir = ~v;
    rvalid = 1'h1;
    host.tick(1);
    rvalid = 1'h0;
  endtask : meas

  initial begin
    #150_000;
    fail_count++;
    stop_test();
  end

  initial begin
    logic [15:0] w;
    logic [15:0] l1;
    logic [7:0] c0;
    logic [7:0] c1;
    rst = 1'h1;
    rvalid = 1'h0;
    light = 16'h0000;
    ir = 16'h0000;
    int_req = 1'h0;
    flags = 8'h00;
    void'($urandom(7199));
    host.tick(4);
    rst = 1'h0;
    host.tick(3);
    check({conf1_a, conf0_a}, 16'h0001);
    check({14'h0000, cpd_a, chpd_a}, 16'h0002);
    c0 = (8'($urandom()) & 8'hFA) | 8'h02;
    c1 = 8'($urandom()) & 8'h7F;
    wr_word(8'h52, 8'h00, {c1, c0});
    int_req = 1'h1;
    host.tick(4);
    check({conf1_a, conf0_a}, {c1, c0});
    check({14'h0000, cpd_a, chpd_a}, 16'h0000);
    check({15'h0000, int_oe_a}, 16'h0001);
    l1 = 16'($urandom());
    meas(l1);
    rd_word(8'h10, w);
    check(w, l1);
    rd_word(8'h12, w);
    check(w, ~l1);
    wr_word(8'h52, 8'h00, 16'h8001);
    check({14'h0000, cpd_a, chpd_a}, 16'h0003);
    check({15'h0000, int_oe_a}, 16'h0000);
    rd_word(8'h10, w);
    check(w, l1);
    meas(~l1);
    rd_word(8'h10, w);
    check(w, l1);
    flags = 8'($urandom());
    foreach (undef[i]) begin
      rd_word(undef[i], w);
      check(w, exp_undef(undef[i], flags));
    end
    // stall with the clock low while the target acknowledges
    w = 16'h0052;
    host.start_cond();
    for (int i = 7; i >= 0; i--) host.bit_io(w[i], w[15]);
    host.tick(20);
    check({15'h0000, oe_a}, 16'h0001);
    host.tick(TO_CYC + 20);
    check({15'h0000, to_seen}, 16'h0001);
    check({14'h0000, oe_a, oe_b}, 16'h0000);
    host.stop_cond();
    c0 = 8'($urandom()) & 8'hFA;
    c1 = 8'($urandom()) & 8'h7F;
    wr_word(8'h52, 8'h00, {c1, c0});
    check({conf1_a, conf0_a}, {c1, c0});
    l1 = 16'($urandom()) & 16'h7FFA;
    wr_word(8'h20, 8'h00, l1);
    check({conf1_b, conf0_b}, l1);
    check({conf1_a, conf0_a}, {c1, c0});
    // threshold words, low byte at the code and high byte at the next one
    l1 = 16'($urandom());
    wr_word(8'h52, 8'h04, l1);
    w = 16'($urandom());
    wr_word(8'h52, 8'h06, w);
    check(thr_hi_a, l1);
    check(thr_lo_a, w);
    // trigger bit gives one pulse and reads back cleared
    wr_word(8'h52, 8'h00, {c1, c0 | 8'h04});
    check(16'(trig_cnt), 16'h0001);
    check({conf1_a, conf0_a}, {c1, exp_conf0(c0 | 8'h04)});
    nk_any = 1'h0;
    host.start_cond();
    put(8'h54);
    host.stop_cond();
    check({15'h0000, nk_any}, 16'h0001);
    check({15'h0000, hi_seen}, 16'h0000);
    stop_test();
  end
endmodule : lsp_target_bench

`default_nettype wire
